// [src/sfcf_pkg.sv]
package sfcf_pkg;
	// opcodes
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRITE_UNLOCK_CMD = 8'h06;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_DUAL = 8'h3B;
	localparam logic [7:0] OP_UID = 8'h4B;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_CE_A = 8'h60;
	localparam logic [7:0] OP_LEGID = 8'h90;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_CE_B = 8'hC7;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	// byte positions within a frame (count of whole bytes seen)
	localparam logic [4:0] IDX_OPCODE = 5'h01;
	localparam logic [4:0] IDX_SR_DATA = 5'h02;
	localparam logic [4:0] IDX_AFTER_ADDR = 5'h04;
	localparam logic [4:0] IDX_AFTER_DUMMY = 5'h05;
	localparam logic [4:0] IDX_MAX = 5'h1F;
	localparam logic [4:0] UID_BYTES = 5'h10;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] DUAL_BIT_LAST = 3'h3;
	// status_byte layout
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 4;
	localparam int ST_SRP = 7;
	// apb register map
	localparam logic [7:0] REG_BUSY_TIME = 8'h00;
	localparam logic [7:0] REG_ARRAY_DATA = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_LAST_CMD = 8'h0C;
	localparam logic [15:0] BUSY_TIME_RST = 16'h0040;
	localparam logic [7:0] ARRAY_DATA_RST = 8'hFF;
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	// frame phase
	typedef enum logic [2:0] {PH_IDLE, PH_OPCODE, PH_BODY, PH_SEND, PH_SKIP} sfcf_phase_t;
endpackage

// [src/sfcf_top.sv]
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
module sfcf_top #(
	parameter logic [7:0] MANUF_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h3C, // arbitrary value
	parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // arbitrary
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic select_bar,
	input wire logic serial_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	output logic dual_line_0,
	output logic dual_line_0_oe
);
	import sfcf_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic sck_m; // first synchroniser stages
		logic csn_m;
		logic si_m;
		logic sck_s; // second stages
		logic csn_s;
		logic si_s;
		logic sck_d; // previous value for edges
		logic csn_d;
		sfcf_phase_t phase;
		logic [2:0] bitcnt; // bits of the current byte
		logic [4:0] idx; // whole bytes seen, saturating
		logic [7:0] shreg; // input shifter
		logic [7:0] op;
		logic [23:0] addr;
		logic busy;
		logic [15:0] bcnt; // internal cycle countdown
		logic write_latch_flag;
		logic [2:0] bp;
		logic status_protect_bit;
		logic dpd; // deep power-down
		logic [15:0] busy_time;
		logic [7:0] array_data;
		logic [7:0] last_op;
		logic [23:0] last_addr;
		logic so;
		logic so_oe;
		logic d0;
		logic d0_oe;
		logic [31:0] rdata;
		logic err;
	} sfcf_state_t;

	sfcf_state_t st; // registered state
	sfcf_state_t nx; // next state

	logic sck_rise; // serial clock edges seen in pclk domain
	logic sck_fall;
	logic csn_rise;
	logic csn_fall;
	logic [7:0] status_byte;
	logic [7:0] new_byte; // byte completing on this rising edge
	logic byte_done;
	logic dual_mode;
	logic [4:0] tx_start; // byte index where output starts
	logic [7:0] tx_byte; // byte being shifted out
	logic [3:0] uid_k;
	logic whole; // frame ended on a byte boundary
	logic exec_go; // write-type command starts internal cycle
	logic apb_setup;
	logic apb_write;

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers
	always_comb
	begin
		sck_rise = st.sck_s & ~st.sck_d;
		sck_fall = ~st.sck_s & st.sck_d;
		csn_rise = st.csn_s & ~st.csn_d;
		csn_fall = ~st.csn_s & st.csn_d;
		// volatile bits come from live state, never from a write
		status_byte = 8'h00;
		status_byte[ST_BUSY] = st.busy;
		status_byte[ST_WEL] = st.write_latch_flag;
		status_byte[ST_BP_HI:ST_BP_LO] = st.bp;
		status_byte[ST_SRP] = st.status_protect_bit;
		new_byte = {st.shreg[6:0], st.si_s};
		dual_mode = (st.op == OP_DUAL) && (st.phase == PH_SEND);
		// dual output packs a byte into four clocks
		byte_done = dual_mode ? (st.bitcnt == DUAL_BIT_LAST) : (st.bitcnt == BIT_LAST);
		// where each read-type opcode starts driving
		case (st.op)
			OP_RDSR: tx_start = IDX_OPCODE;
			OP_READ: tx_start = IDX_AFTER_ADDR;
			OP_FAST, OP_DUAL, OP_UID: tx_start = IDX_AFTER_DUMMY;
			OP_WAKE, OP_LEGID: tx_start = IDX_AFTER_ADDR;
			default: tx_start = 5'h00;
		endcase
		uid_k = 4'(st.idx - IDX_AFTER_DUMMY);
		case (st.op)
			OP_RDSR: tx_byte = status_byte;
			OP_READ, OP_FAST, OP_DUAL: tx_byte = st.array_data;
			OP_UID:
				if ((st.idx - IDX_AFTER_DUMMY) < UID_BYTES)
					tx_byte = UNIQUE_ID[{~uid_k, 3'h7} -: 8];
				else
					tx_byte = FILL_BYTE;
			OP_WAKE: tx_byte = DEVICE_CODE;
			OP_LEGID: // alternate codes; address bit 0 picks the first
				if (st.idx[0] ^ st.addr[0])
					tx_byte = DEVICE_CODE;
				else
					tx_byte = MANUF_CODE;
			default: tx_byte = FILL_BYTE;
		endcase
		whole = (st.bitcnt == 3'h0);
		// write-type commands need the latch and an exact length, except page program, which needs at least one data byte
		case (st.op)
			OP_WRSR: exec_go = st.write_latch_flag && (st.idx == IDX_SR_DATA);
			OP_PP: exec_go = st.write_latch_flag && (st.idx > IDX_AFTER_ADDR);
			OP_SE, OP_BE32, OP_BE64: exec_go = st.write_latch_flag && (st.idx == IDX_AFTER_ADDR);
			OP_CE_A, OP_CE_B: exec_go = st.write_latch_flag && (st.idx == IDX_OPCODE);
			default: exec_go = 1'b0;
		endcase
		exec_go = exec_go && whole && csn_rise && (st.phase == PH_BODY);
		apb_setup = psel && !penable;
		apb_write = psel && penable && pwrite;
	end

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		nx = st;
		// two flops before anything looks at a pin
		nx.sck_m = serial_clk;
		nx.csn_m = select_bar;
		nx.si_m = serial_in;
		nx.sck_s = st.sck_m;
		nx.csn_s = st.csn_m;
		nx.si_s = st.si_m;
		nx.sck_d = st.sck_s;
		nx.csn_d = st.csn_s;

		// internal cycle countdown
		if (st.busy)
		begin
			if (st.bcnt == 16'h0000)
			begin
				nx.busy = 1'b0;
				nx.write_latch_flag = 1'b0;
			end
			else
				nx.bcnt = st.bcnt - 16'h0001;
		end

		// frame sequencing
		if (csn_fall)
		begin
			nx.phase = PH_OPCODE;
			nx.bitcnt = 3'h0;
			nx.idx = 5'h00;
		end
		else if (st.csn_s)
		begin
			// frame ends: outputs released whatever bit we were on
			nx.phase = PH_IDLE;
			nx.so_oe = 1'b0;
			nx.d0_oe = 1'b0;
			if (csn_rise && whole && (st.phase == PH_BODY || st.phase == PH_SEND))
			begin
				if (st.op == OP_WRITE_UNLOCK_CMD && st.idx == IDX_OPCODE)
					nx.write_latch_flag = 1'b1;
				if (st.op == OP_WRDI && st.idx == IDX_OPCODE)
					nx.write_latch_flag = 1'b0;
				if (st.op == OP_SLEEP && st.idx == IDX_OPCODE)
					nx.dpd = 1'b1;
			end
			// wake is a read-type command: any clocked bit after opcode
			if (csn_rise && st.op == OP_WAKE && st.phase != PH_OPCODE && st.phase != PH_IDLE)
				nx.dpd = 1'b0;
			if (exec_go)
			begin
				// stays active until this cycle completes
				nx.busy = 1'b1;
				nx.bcnt = st.busy_time;
				nx.last_op = st.op;
				nx.last_addr = st.addr;
				if (st.op == OP_WRSR)
				begin
					nx.bp = st.shreg[ST_BP_HI:ST_BP_LO];
					nx.status_protect_bit = st.shreg[ST_SRP];
				end
			end
		end
		else if (sck_rise && st.phase != PH_IDLE)
		begin
			nx.shreg = new_byte;
			nx.bitcnt = byte_done ? 3'h0 : st.bitcnt + 3'h1;
			if (byte_done)
			begin
				nx.idx = (st.idx == IDX_MAX) ? IDX_MAX : st.idx + 5'h01;
				if (st.phase == PH_OPCODE)
				begin
					nx.op = new_byte;
					// busy and deep sleep filter what is accepted
					if ((st.busy && new_byte != OP_RDSR) ||
						(st.dpd && new_byte != OP_WAKE))
						nx.phase = PH_SKIP;
					else if (new_byte == OP_RDSR)
						nx.phase = PH_SEND;
					else
						nx.phase = PH_BODY;
				end
				else if (st.phase == PH_BODY)
				begin
					if (st.idx < IDX_AFTER_ADDR)
						nx.addr = {st.addr[15:0], new_byte};
					if (tx_start != 5'h00 && st.idx + 5'h01 >= tx_start)
						nx.phase = PH_SEND;
				end
			end
		end
		else if (sck_fall && st.phase == PH_SEND)
		begin
			// output changes on the falling clock, msb first
			if (dual_mode)
			begin
				nx.so = tx_byte[{~st.bitcnt[1:0], 1'b1}];
				nx.d0 = tx_byte[{~st.bitcnt[1:0], 1'b0}];
				nx.so_oe = 1'b1;
				nx.d0_oe = 1'b1;
			end
			else
			begin
				nx.so = tx_byte[~st.bitcnt];
				nx.so_oe = 1'b1;
			end
		end

		// apb: read data captured in setup, answered in access
		if (apb_setup)
		begin
			nx.rdata = 32'h0000_0000;
			nx.err = 1'b0;
			case (paddr)
				REG_BUSY_TIME: nx.rdata = {16'h0000, st.busy_time};
				REG_ARRAY_DATA: nx.rdata = {24'h000000, st.array_data};
				REG_STATE: nx.rdata = {21'h000000, st.csn_s, ~st.csn_s | st.busy, st.dpd,
					status_byte};
				REG_LAST_CMD: nx.rdata = {st.last_addr, st.last_op};
				default: nx.err = 1'b1; // unmapped
			endcase
		end
		if (apb_write)
		begin
			case (paddr)
				REG_BUSY_TIME: nx.busy_time = pwdata[15:0];
				REG_ARRAY_DATA: nx.array_data = pwdata[7:0];
				default: nx.busy_time = st.busy_time; // read-only or unmapped
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; select_bar idles high so its sync flops reset high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.sck_m <= 1'b0;
			st.csn_m <= 1'b1;
			st.csn_s <= 1'b1;
			st.csn_d <= 1'b1;
			st.phase <= PH_IDLE;
			st.write_latch_flag <= 1'b0;
			st.busy_time <= BUSY_TIME_RST;
			st.array_data <= ARRAY_DATA_RST;
		end
		else
			st <= nx;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb
	begin
		prdata = st.rdata;
		pready = 1'b1; // zero wait states
		pslverr = st.err && psel && penable;
		serial_out = st.so;
		serial_out_oe = st.so_oe;
		dual_line_0 = st.d0;
		dual_line_0_oe = st.d0_oe;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_deselect_release: assert property (@(posedge pclk) disable iff (!presetn)
		st.csn_s |=> !serial_out_oe && !dual_line_0_oe)
		else $error("output still driven after deselect");

	a_active_while_busy: assert property (@(posedge pclk) disable iff (!presetn)
		st.busy |-> ##1 (st.busy || !st.write_latch_flag))
		else $error("cycle ended without clearing latch");

	a_latch_clear_end: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(st.busy) |-> !st.write_latch_flag)
		else $error("latch set after internal cycle");

	a_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		(st.busy && sck_rise && byte_done && st.phase == PH_OPCODE && new_byte != OP_RDSR)
		|=> st.phase == PH_SKIP)
		else $error("command accepted while busy");

	a_sleep_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		(st.dpd && !(csn_rise && st.op == OP_WAKE)) |=> st.dpd && !$rose(st.busy))
		else $error("deep sleep left or cycle started");

	a_partial_byte: assert property (@(posedge pclk) disable iff (!presetn)
		(csn_rise && st.bitcnt != 3'h0) |=> !$rose(st.busy) && ($stable(st.write_latch_flag) || $fell(st.busy)))
		else $error("partial byte command executed");

	a_status_msb: assert property (@(posedge pclk) disable iff (!presetn)
		(sck_fall && !st.csn_s && st.op == OP_RDSR && st.phase == PH_SEND
		&& st.bitcnt == 3'h0) |=> serial_out == $past(status_byte[ST_SRP]) && serial_out_oe)
		else $error("status msb not presented");

	a_dual_split: assert property (@(posedge pclk) disable iff (!presetn)
		(sck_fall && !st.csn_s && dual_mode && st.bitcnt == 3'h0)
		|=> dual_line_0 == $past(tx_byte[6]) && serial_out == $past(tx_byte[7]))
		else $error("dual bit pairing wrong");

	a_write_unlock_cmd_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(csn_rise && whole && st.phase == PH_BODY && st.op == OP_WRITE_UNLOCK_CMD && st.idx == IDX_OPCODE)
		|=> st.write_latch_flag ##1 st.write_latch_flag)
		else $error("write enable did not set latch");

	a_wrdi_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(csn_rise && whole && st.phase == PH_BODY && st.op == OP_WRDI && st.idx == IDX_OPCODE)
		|=> !st.write_latch_flag)
		else $error("write disable did not clear latch");
endmodule

// [tb/sfcf_host.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
// host spi controller, mode 0, clock idles low between frames
module sfcf_host(
	input wire logic pclk,
	output logic select_bar,
	output logic serial_clk,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic dual_line_0
);
	logic [7:0] rxq[$]; // bytes read back in the last frame
	initial
	begin
		select_bar = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end
	// one 320 ns clock: 4 pclk low, 4 pclk high; sample half a pclk before the falling edge
	task automatic tick(input logic b, output logic [1:0] r);
		serial_in <= b;
		repeat (4) @(posedge pclk);
		serial_clk <= 1'b1;
		repeat (3) @(posedge pclk);
		@(negedge pclk) r = {serial_out, dual_line_0};
		@(posedge pclk) serial_clk <= 1'b0;
	endtask
	// whole bytes out msb first, then n reads, then x stray bits
	task automatic frame(input logic [7:0] tx[$], input int n, input bit d, input int x);
		logic [1:0] r;
		logic [7:0] v;
		rxq = {};
		select_bar <= 1'b0;
		foreach (tx[i])
			for (int k = 7; k >= 0; k--)
				tick(tx[i][k], r);
		for (int i = 0; i < n; i++)
		begin
			v = 8'h00;
			// dual reads take two bits per clock, odd bit on serial_out
			for (int k = 0; k < (d ? 4 : 8); k++)
			begin
				tick(~serial_in, r);
				v = d ? {v[5:0], r} : {v[6:0], r[1]};
			end
			rxq.push_back(v);
		end
		for (int k = 0; k < x; k++)
			tick(~serial_in, r);
		repeat (4) @(posedge pclk);
		select_bar <= 1'b1;
		serial_in <= ~serial_in; // released line shows no stale value
		repeat (8) @(posedge pclk);
	endtask
endmodule

// [tb/serial_flash_command_front_end_tb.sv]
`timescale 1ns/100ps
module serial_flash_command_front_end_tb;
	import sfcf_pkg::*;
	localparam logic [7:0] MANUF = 8'hA5; // arbitrary value
	localparam logic [7:0] DEV = 8'h3C; // arbitrary value
	localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF; // arbitrary
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, v;
	logic select_bar, serial_clk, serial_in, serial_out, serial_out_oe;
	logic dual_line_0, dual_line_0_oe, er;
	int fails, checks_done, m_nv, m_wel, m_busy, m_arr; // model state
	sfcf_top #(.MANUF_CODE(MANUF), .DEVICE_CODE(DEV), .UNIQUE_ID(UID)) sfcf_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .select_bar(select_bar),
		.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .dual_line_0(dual_line_0),
		.dual_line_0_oe(dual_line_0_oe));
	sfcf_host sfcf_host_inst (.pclk(pclk), .select_bar(select_bar),
		.serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out),
		.dual_line_0(dual_line_0));
	////////////////////////////////////////////////////////////////
	initial pclk = 1'b0;
	always #20 pclk = ~pclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected status from the model
	function automatic logic [7:0] exp_st();
		return 8'(m_nv | (m_wel << 1) | m_busy);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// apb cycle; held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk) penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic run(input logic [7:0] tx[$], input int n, input bit d, input int x);
		sfcf_host_inst.frame(tx, n, d, x);
	endtask
	// status read of two bytes: repeat of the same value
	task automatic st();
		run({OP_RDSR}, 2, 1'b0, 0);
		chk(sfcf_host_inst.rxq[0], exp_st());
		chk(sfcf_host_inst.rxq[1], exp_st());
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog: whole run needs about 12600 pclk
	initial
	begin
		repeat (80000) @(posedge pclk);
		fails++;
		results();
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		seed = 32'h0000416F;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{fails, checks_done, m_nv, m_wel, m_busy} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, REG_BUSY_TIME, 32'h0);
		chk(rd, {16'h0, BUSY_TIME_RST});
		apb(1'b0, 8'h10, 32'h0);
		chk({er, rd}, {1'b1, 32'h0}); // unmapped
		apb(1'b1, REG_BUSY_TIME, 32'h800);
		v = rnd();
		apb(1'b1, REG_ARRAY_DATA, {24'h0, v[7:0]});
		m_arr = v[7:0];
		apb(1'b0, REG_ARRAY_DATA, 32'h0);
		chk(rd, {24'h0, v[7:0]});
		st();
		run({OP_RDSR}, 0, 1'b0, 3);
		chk({serial_out_oe, dual_line_0_oe}, 2'b00);
		run({OP_WRITE_UNLOCK_CMD}, 0, 1'b0, 0);
		m_wel = 1;
		st();
		run({OP_WRDI}, 0, 1'b0, 0);
		m_wel = 0;
		st();
		run({OP_WRITE_UNLOCK_CMD}, 0, 1'b0, 0);
		m_wel = 1;
		run({OP_WRSR}, 0, 1'b0, 4);
		st();
		v = rnd();
		run({OP_WRSR, v[7:0]}, 0, 1'b0, 0);
		m_nv = v & 32'h9C;
		m_busy = 1;
		st();
		run({OP_WRDI}, 0, 1'b0, 0);
		st();
		apb(1'b0, REG_STATE, 32'h0);
		chk(rd[9:0], {2'b10, exp_st()});
		repeat (2100) @(posedge pclk);
		{m_busy, m_wel} = '0;
		st();
		apb(1'b0, REG_STATE, 32'h0);
		chk(rd[9:0], {2'b00, exp_st()});
		// both chip erase codes start a busy cycle
		for (int i = 0; i < 2; i++)
		begin
			run({OP_WRITE_UNLOCK_CMD}, 0, 1'b0, 0);
			run({i ? OP_CE_B : OP_CE_A}, 0, 1'b0, 0);
			{m_busy, m_wel} = {32'h1, 32'h1};
			st();
			repeat (2100) @(posedge pclk);
			{m_busy, m_wel} = '0;
			st();
		end
		run({OP_LEGID, 8'h00, 8'h00, 8'h00}, 2, 1'b0, 0);
		chk({sfcf_host_inst.rxq[0], sfcf_host_inst.rxq[1]}, {MANUF, DEV});
		run({OP_LEGID, 8'h00, 8'h00, 8'h01}, 2, 1'b0, 0);
		chk({sfcf_host_inst.rxq[0], sfcf_host_inst.rxq[1]}, {DEV, MANUF});
		run({OP_SLEEP}, 0, 1'b0, 0);
		run({OP_WRITE_UNLOCK_CMD}, 0, 1'b0, 0);
		run({OP_WAKE, 8'h00, 8'h00, 8'h00}, 2, 1'b0, 0);
		chk({sfcf_host_inst.rxq[0], sfcf_host_inst.rxq[1]}, {DEV, DEV});
		st();
		apb(1'b0, REG_ARRAY_DATA, 32'h0);
		chk(rd, m_arr);
		v = rnd();
		run({OP_READ, v[23:16], v[15:8], v[7:0]}, 1, 1'b0, 0);
		chk(sfcf_host_inst.rxq[0], m_arr);
		run({OP_FAST, v[23:16], v[15:8], v[7:0], 8'h00}, 1, 1'b0, 0);
		chk(sfcf_host_inst.rxq[0], m_arr);
		run({OP_DUAL, v[23:16], v[15:8], v[7:0], 8'h00}, 1, 1'b1, 0);
		chk(sfcf_host_inst.rxq[0], m_arr);
		run({OP_UID, v[23:16], v[15:8], v[7:0], 8'h00}, 2, 1'b0, 0);
		chk({sfcf_host_inst.rxq[0], sfcf_host_inst.rxq[1]}, UID[127:112]);
		results();
	end
endmodule
